// ---- rtl/twm_map.svh ----
// Purpose: register offsets, field positions and constants of the two-wire master
// Assumes: byte addresses, one 32-bit word per register
// Notes: included by bare name
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define TWM_OFS_CTRL 8'h00
`define TWM_OFS_MODE 8'h04
`define TWM_OFS_INNER 8'h0C
`define TWM_OFS_CWG 8'h10
`define TWM_OFS_STAT 8'h20
`define TWM_OFS_IEN 8'h24
`define TWM_OFS_IDIS 8'h28
`define TWM_OFS_IMSK 8'h2C
`define TWM_OFS_RXHOLD 8'h30
`define TWM_OFS_TXHOLD 8'h34
// ----------------------------------------
// control command bits
// ----------------------------------------
`define TWM_CR_START 0
`define TWM_CR_STOP 1
`define TWM_CR_EN 2
`define TWM_CR_DIS 3
`define TWM_CR_RST 7
// ----------------------------------------
// mode and clock waveform fields
// ----------------------------------------
`define TWM_MR_IASZ 9:8
`define TWM_MR_READ 12
`define TWM_MR_SLV 22:16
`define TWM_CW_LO 7:0
`define TWM_CW_HI 15:8
`define TWM_CW_EXP 18:16
`define TWM_CW_ADD 16'h0003
// ----------------------------------------
// status bits and resets
// ----------------------------------------
`define TWM_SR_DONE 0
`define TWM_SR_RX 1
`define TWM_SR_TX 2
`define TWM_SR_NAK 8
`define TWM_SR_RESET 32'h0000_0008
`define TWM_ACK_BIT 4'h8
`endif

// ---- rtl/twm_pkg.sv ----
// Purpose: types of the two-wire master
// Assumes: nothing
// Notes: offsets live in twm_map.svh
package twm_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h0,
      ST_START = 4'h1,
      ST_BLO = 4'h2,
      ST_BHI = 4'h3,
      ST_RSLO = 4'h4,
      ST_RSHI = 4'h5,
      ST_PLO = 4'h6,
      ST_PHI = 4'h7,
      ST_PEND = 4'h8
   } twm_state_t;
   typedef enum logic [1:0] {K_ADDR = 2'h0, K_INNER = 2'h1, K_DATA = 2'h2} twm_kind_t;
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
      logic hready;
   } twm_ahb_req_t;
   typedef struct packed {
      logic hreadyout;
      logic hresp;
      logic [31:0] hrdata;
   } twm_ahb_rsp_t;
   typedef struct packed {
      logic [15:0] cnt;
      logic done;
   } twm_tmr_t;
   typedef struct packed {
      twm_state_t fsm;
      twm_kind_t kind;
      logic [3:0] bitn;
      logic [7:0] shreg;
      logic [1:0] iacnt;
      logic rd_ph;
      logic stop_req;
      logic dis_pend;
      logic master_enable_cmd;
      logic [7:0] txhold;
      logic tx_full;
      logic [7:0] rxhold;
      logic done;
      logic rx_rdy;
      logic tx_rdy;
      logic nak;
      logic [3:0] imr;
      logic [1:0] iasz;
      logic rd_dir;
      logic [6:0] slv;
      logic [23:0] inner;
      logic [7:0] lo_div;
      logic [7:0] hi_div;
      logic [2:0] exp;
      logic wr_pend;
      logic [7:0] wr_addr;
      twm_ahb_rsp_t rsp;
      logic irq;
      logic od_lvl;
      logic scl_oe;
      logic sda_oe;
      logic scl_s1;
      logic scl_s2;
      logic sda_s1;
      logic sda_s2;
   } twm_regs_t;
endpackage

// ---- rtl/twm_phase_timer.sv ----
// Purpose: down counter timing one serial clock phase
// Assumes: load value is phase length minus one
// Notes: done is a one-cycle pulse from a flop
module twm_phase_timer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [15:0] value,
   output logic done
);
   twm_pkg::twm_tmr_t st_q;
   twm_pkg::twm_tmr_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.done = (st_q.cnt == 16'h0001) && !load;
      if (load) begin
         st_d.cnt = value;
      end else if (st_q.cnt != 16'h0000) begin
         st_d.cnt = st_q.cnt - 16'h0001;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign done = st_q.done;
endmodule

// ---- rtl/twm_regs_top.sv ----
// Purpose: two-wire serial bus master with its AHB-Lite register set
// Assumes: one clock sys_clk, synchronous active-high rst, open-drain pads outside
// Notes: zero-wait-state slave; response always OKAY
// Functional notes
// - start bit launches a frame from mode
// - write direction: holding write launches frame
// - stop bit ends after current byte
// - read direction: not-acknowledge forces stop
// - write: stop when holding and shifter empty
// - enable bit enables unless disable also set
// - disable waits for pending bytes to finish
// - soft reset bit equals system reset
// - size field selects zero to three bytes
// - direction bit: zero write, one read
// - slave address field selects target device
// - inner address bytes, low byte in 10-bit
// - low time is divider shifted plus three
// - high time is divider shifted plus three
// - done flag low in frame, set after stop
// - receive flag set on byte, cleared on read
// - transmit flag rules for write, load, enable
// - not-acknowledged flag set, cleared by status read
// - enable set and disable clear mask bits
// - received byte low eight, send byte low eight
// - eight bits msb first, then acknowledge
// - start and stop edges while clock high
// - seven-bit address then direction bit
`include "twm_map.svh"
module twm_regs_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire twm_pkg::twm_ahb_req_t ahb_req,
   output twm_pkg::twm_ahb_rsp_t ahb_rsp,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   output logic irq
);
   localparam twm_pkg::twm_regs_t RST_V = '{
      fsm: twm_pkg::ST_IDLE,
      kind: twm_pkg::K_ADDR,
      rsp: '{hreadyout: 1'b1, hresp: 1'b0, hrdata: 32'h0000_0000},
      default: '0
   };

   twm_pkg::twm_regs_t st_q;
   twm_pkg::twm_regs_t st_d;
   logic t_ld;
   logic [15:0] t_val;
   logic t_done;
   logic rx_evt;
   logic nak_evt;
   logic go;
   logic rx;
   logic drive;
   logic [15:0] lo_v;
   logic [15:0] hi_v;
   logic [31:0] rdv;
   logic [31:0] wd;
   logic av;
   logic wr_ctl;
   logic wr_tx;
   logic wr_ien;
   logic idle;

   // ----------------------------------------
   // phase timing
   // ----------------------------------------
   assign lo_v = ({8'h00, st_q.lo_div} << st_q.exp) + `TWM_CW_ADD - 16'h0001;
   assign hi_v = ({8'h00, st_q.hi_div} << st_q.exp) + `TWM_CW_ADD - 16'h0001;

   twm_phase_timer u_tmr (
      .sys_clk(sys_clk),
      .rst(rst || (wr_ctl && wd[`TWM_CR_RST])),
      .load(t_ld),
      .value(t_val),
      .done(t_done)
   );

   // ----------------------------------------
   // bus decode and read mux
   // ----------------------------------------
   assign wd = ahb_req.hwdata;
   assign av = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
   assign wr_ctl = st_q.wr_pend && (st_q.wr_addr == `TWM_OFS_CTRL);
   assign wr_tx = st_q.wr_pend && (st_q.wr_addr == `TWM_OFS_TXHOLD);
   assign wr_ien = st_q.wr_pend && (st_q.wr_addr == `TWM_OFS_IEN);
   assign idle = st_q.fsm == twm_pkg::ST_IDLE;
   assign rx = st_q.rd_ph && (st_q.kind == twm_pkg::K_DATA);
   // data bits msb first, ack released by transmitter, master acks reads unless a stop is requested
   assign drive = (st_q.bitn == `TWM_ACK_BIT) ? (rx && !st_q.stop_req) : (!rx && !st_q.shreg[7]);

   always_comb begin
      case (ahb_req.haddr[7:0])
         `TWM_OFS_MODE: rdv = {9'h000, st_q.slv, 3'h0, st_q.rd_dir, 2'h0, st_q.iasz, 8'h00};
         `TWM_OFS_INNER: rdv = {8'h00, st_q.inner};
         `TWM_OFS_CWG: rdv = {13'h0000, st_q.exp, st_q.hi_div, st_q.lo_div};
         `TWM_OFS_STAT: rdv = {23'h000000, st_q.nak, 5'h00, st_q.tx_rdy, st_q.rx_rdy, st_q.done} | `TWM_SR_RESET;
         `TWM_OFS_IMSK: rdv = {23'h000000, st_q.imr[3], 5'h00, st_q.imr[2:0]};
         `TWM_OFS_RXHOLD: rdv = {24'h000000, st_q.rxhold};
         `TWM_OFS_TXHOLD: rdv = {24'h000000, st_q.txhold};
         default: rdv = 32'h0000_0000;
      endcase
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      st_d = st_q;
      t_ld = 1'b0;
      t_val = lo_v;
      rx_evt = 1'b0;
      nak_evt = 1'b0;
      go = 1'b0;
      st_d.scl_s1 = scl_i;
      st_d.scl_s2 = st_q.scl_s1;
      st_d.sda_s1 = sda_i;
      st_d.sda_s2 = st_q.sda_s1;
      st_d.wr_pend = av && ahb_req.hwrite;
      if (av) begin
         st_d.wr_addr = ahb_req.haddr[7:0];
      end
      if (av && !ahb_req.hwrite) begin
         st_d.rsp.hrdata = rdv;
         if (ahb_req.haddr[7:0] == `TWM_OFS_STAT) begin
            st_d.nak = 1'b0;
         end
         if (ahb_req.haddr[7:0] == `TWM_OFS_RXHOLD) begin
            st_d.rx_rdy = 1'b0;
         end
      end
      if (wr_ctl) begin
         go = wd[`TWM_CR_START];
         if (wd[`TWM_CR_STOP]) begin
            st_d.stop_req = 1'b1;
         end
         if (wd[`TWM_CR_EN] && !wd[`TWM_CR_DIS]) begin
            st_d.master_enable_cmd = 1'b1;
            st_d.done = 1'b1;
            st_d.tx_rdy = 1'b1;
         end
         if (wd[`TWM_CR_DIS]) begin
            st_d.dis_pend = 1'b1;
            if (st_q.rd_dir && !idle) begin
               st_d.stop_req = 1'b1;
            end
         end
      end
      if (st_q.wr_pend) begin
         case (st_q.wr_addr)
            `TWM_OFS_MODE: begin
               st_d.iasz = wd[`TWM_MR_IASZ];
               st_d.rd_dir = wd[`TWM_MR_READ];
               st_d.slv = wd[`TWM_MR_SLV];
            end
            `TWM_OFS_INNER: st_d.inner = wd[23:0];
            `TWM_OFS_CWG: begin
               st_d.lo_div = wd[`TWM_CW_LO];
               st_d.hi_div = wd[`TWM_CW_HI];
               st_d.exp = wd[`TWM_CW_EXP];
            end
            `TWM_OFS_IEN: st_d.imr = st_q.imr | {wd[`TWM_SR_NAK], wd[2:0]};
            `TWM_OFS_IDIS: st_d.imr = st_q.imr & ~{wd[`TWM_SR_NAK], wd[2:0]};
            `TWM_OFS_TXHOLD: begin
               st_d.txhold = wd[7:0];
               st_d.tx_full = 1'b1;
               st_d.tx_rdy = 1'b0;
               go = go || !st_q.rd_dir;
            end
            default: begin
            end
         endcase
      end
      if (st_q.dis_pend && idle && !go) begin
         st_d.master_enable_cmd = 1'b0;
         st_d.dis_pend = 1'b0;
      end
      case (st_q.fsm)
         twm_pkg::ST_IDLE: begin
            if (go && st_q.master_enable_cmd) begin
               st_d.fsm = twm_pkg::ST_START;
               st_d.sda_oe = 1'b1;
               st_d.done = 1'b0;
               st_d.kind = twm_pkg::K_ADDR;
               st_d.bitn = 4'h0;
               st_d.rd_ph = st_q.rd_dir && (st_q.iasz == 2'h0);
               st_d.shreg = {st_q.slv, st_q.rd_dir && (st_q.iasz == 2'h0)};
               t_ld = 1'b1;
               t_val = hi_v;
            end
         end
         twm_pkg::ST_START: begin
            if (t_done) begin
               st_d.fsm = twm_pkg::ST_BLO;
               st_d.scl_oe = 1'b1;
               t_ld = 1'b1;
            end
         end
         twm_pkg::ST_BLO: begin
            st_d.sda_oe = drive;
            if (t_done) begin
               st_d.fsm = twm_pkg::ST_BHI;
               st_d.scl_oe = 1'b0;
               t_ld = 1'b1;
               t_val = hi_v;
            end
         end
         twm_pkg::ST_BHI: begin
            if (t_done) begin
               st_d.fsm = twm_pkg::ST_BLO;
               st_d.scl_oe = 1'b1;
               t_ld = 1'b1;
               if (st_q.bitn != `TWM_ACK_BIT) begin
                  st_d.bitn = st_q.bitn + 4'h1;
                  st_d.shreg = {st_q.shreg[6:0], rx && st_q.sda_s2};
                  if (rx && (st_q.bitn == 4'h7)) begin
                     st_d.rxhold = {st_q.shreg[6:0], st_q.sda_s2};
                     st_d.rx_rdy = 1'b1;
                     rx_evt = 1'b1;
                  end
               end else begin
                  st_d.bitn = 4'h0;
                  if (!rx && st_q.sda_s2) begin
                     nak_evt = 1'b1;
                     st_d.nak = 1'b1;
                     st_d.done = 1'b1;
                     st_d.tx_rdy = 1'b1;
                     st_d.fsm = twm_pkg::ST_PLO;
                  end else if (rx) begin
                     if (st_q.stop_req) begin
                        st_d.fsm = twm_pkg::ST_PLO;
                     end
                  end else if ((st_q.kind == twm_pkg::K_ADDR) && st_q.rd_ph) begin
                     st_d.kind = twm_pkg::K_DATA;
                  end else if ((st_q.kind == twm_pkg::K_ADDR) && (st_q.iasz != 2'h0)) begin
                     st_d.kind = twm_pkg::K_INNER;
                     st_d.iacnt = st_q.iasz - 2'h1;
                     st_d.shreg = ia_byte(st_q.inner, st_q.iasz - 2'h1);
                  end else if ((st_q.kind == twm_pkg::K_INNER) && (st_q.iacnt != 2'h0)) begin
                     st_d.iacnt = st_q.iacnt - 2'h1;
                     st_d.shreg = ia_byte(st_q.inner, st_q.iacnt - 2'h1);
                  end else if ((st_q.kind == twm_pkg::K_INNER) && st_q.rd_dir) begin
                     st_d.fsm = twm_pkg::ST_RSLO;
                     st_d.kind = twm_pkg::K_ADDR;
                     st_d.rd_ph = 1'b1;
                     st_d.shreg = {st_q.slv, 1'b1};
                  end else if ((st_q.kind == twm_pkg::K_DATA) && st_q.stop_req) begin
                     st_d.fsm = twm_pkg::ST_PLO;
                  end else if (st_q.tx_full) begin
                     st_d.kind = twm_pkg::K_DATA;
                     st_d.shreg = st_q.txhold;
                     st_d.tx_full = 1'b0;
                     st_d.tx_rdy = 1'b1;
                  end else begin
                     st_d.fsm = twm_pkg::ST_PLO;
                  end
               end
            end
         end
         twm_pkg::ST_RSLO: begin
            st_d.sda_oe = 1'b0;
            if (t_done) begin
               st_d.fsm = twm_pkg::ST_RSHI;
               st_d.scl_oe = 1'b0;
               t_ld = 1'b1;
               t_val = hi_v;
            end
         end
         twm_pkg::ST_RSHI: begin
            if (t_done) begin
               st_d.fsm = twm_pkg::ST_START;
               st_d.sda_oe = 1'b1;
               t_ld = 1'b1;
               t_val = hi_v;
            end
         end
         twm_pkg::ST_PLO: begin
            st_d.sda_oe = 1'b1;
            if (t_done) begin
               st_d.fsm = twm_pkg::ST_PHI;
               st_d.scl_oe = 1'b0;
               t_ld = 1'b1;
               t_val = hi_v;
            end
         end
         twm_pkg::ST_PHI: begin
            if (t_done) begin
               st_d.fsm = twm_pkg::ST_PEND;
               st_d.sda_oe = 1'b0;
               t_ld = 1'b1;
               t_val = hi_v;
            end
         end
         twm_pkg::ST_PEND: begin
            if (t_done) begin
               st_d.fsm = twm_pkg::ST_IDLE;
               st_d.done = 1'b1;
               st_d.stop_req = 1'b0;
               st_d.rd_ph = 1'b0;
            end
         end
         default: st_d.fsm = twm_pkg::ST_IDLE;
      endcase
      st_d.irq = |({st_q.nak, st_q.tx_rdy, st_q.rx_rdy, st_q.done} & st_q.imr);
      if (wr_ctl && wd[`TWM_CR_RST]) begin
         st_d = RST_V;
      end
   end

   function automatic logic [7:0] ia_byte(input logic [23:0] a, input logic [1:0] i);
      ia_byte = (i == 2'h2) ? a[23:16] : ((i == 2'h1) ? a[15:8] : a[7:0]);
   endfunction

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st_q <= RST_V;
      end else begin
         st_q <= st_d;
      end
   end

   assign ahb_rsp = st_q.rsp;
   assign scl_o = st_q.od_lvl;
   assign sda_o = st_q.od_lvl;
   assign scl_oe = st_q.scl_oe;
   assign sda_oe = st_q.sda_oe;
   assign irq = st_q.irq;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   logic [16:0] lo_cnt;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lo_cnt <= 17'h00000;
      end else begin
         lo_cnt <= st_q.scl_oe ? lo_cnt + 17'h00001 : 17'h00000;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_start_cmd_go: assert property (wr_ctl && wd[0] && !wd[7] && idle && st_q.master_enable_cmd
      |=> st_q.fsm == twm_pkg::ST_START) else $error("start command did not launch");
   a_hold_write_go: assert property (wr_tx && !st_q.rd_dir && idle && st_q.master_enable_cmd && !wr_ctl
      |=> st_q.fsm == twm_pkg::ST_START) else $error("holding write did not launch");
   a_enable_flags: assert property (wr_ctl && wd[2] && !wd[3] && !wd[7] && !wd[0]
      |=> st_q.master_enable_cmd && st_q.done && st_q.tx_rdy) else $error("enable did not set flags");
   a_disable_idle: assert property (wr_ctl && wd[3] && !wd[7] && !wd[0] && idle
      ##1 !go && !wr_ctl |=> !st_q.master_enable_cmd) else $error("disable did not take effect");
   a_soft_reset: assert property (wr_ctl && wd[7]
      |=> idle && !st_q.master_enable_cmd && st_q.imr == 4'h0) else $error("soft reset incomplete");
   a_low_time: assert property ($fell(st_q.scl_oe)
      |-> lo_cnt == {1'b0, lo_v} + 17'h00001) else $error("clock low time wrong");
   a_start_cond: assert property (st_q.fsm == twm_pkg::ST_START
      |-> !st_q.scl_oe && st_q.sda_oe) else $error("start not under high clock");
   a_rx_flag: assert property (rx_evt |=> st_q.rx_rdy) else $error("receive flag lost");
   a_nak_flags: assert property (nak_evt
      |=> st_q.nak && st_q.done && st_q.tx_rdy ##1 st_q.fsm == twm_pkg::ST_PLO) else $error("nak flags wrong");
   a_tx_clear: assert property (wr_tx && idle |=> !st_q.tx_rdy) else $error("transmit flag not cleared");
   a_mask_set: assert property (wr_ien && !wr_ctl
      |=> st_q.imr == ($past(st_q.imr) | {$past(wd[8]), $past(wd[2:0])})) else $error("mask set wrong");
   a_irq_out: assert property ((|({st_q.nak, st_q.tx_rdy, st_q.rx_rdy, st_q.done} & st_q.imr)) && !wr_ctl
      |=> irq) else $error("interrupt not raised");

   c_byte_rx: cover property (rx_evt);
   c_nak_seen: cover property (nak_evt);
   c_restart: cover property (st_q.fsm == twm_pkg::ST_RSHI);
   c_stop_done: cover property (st_q.fsm == twm_pkg::ST_PEND && t_done);
endmodule

// ---- dv/twm_slave_model.sv ----
// Purpose: behavioural slave device on the two-wire bus
// Assumes: line levels sampled on sys_clk, pull-ups on both lines
// Notes: logs every byte it receives, answers reads with rd_byte
module twm_slave_model (
   input wire logic sys_clk,
   input wire logic scl,
   input wire logic sda,
   input wire logic nak_all,
   input wire logic [7:0] rd_byte,
   output logic sda_pull
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scl_q = 1'b1;
   logic sda_q = 1'b1;
   logic rd = 1'b0;
   logic rd_end = 1'b0;
   logic first = 1'b0;
   logic [3:0] bitc = 4'h0;
   logic [7:0] sh = 8'h00;
   logic [7:0] log_q [16];
   int n_log = 0;
   int n_stop = 0;
   initial sda_pull = 1'b0;
   // ----------------------------------------
   // line watcher
   // ----------------------------------------
   always @(posedge sys_clk) begin
      scl_q <= scl;
      sda_q <= sda;
      if (scl && scl_q && sda_q && !sda) begin // start: data falls, clock high
         bitc <= 4'h0;
         first <= 1'b1;
         rd <= 1'b0;
         rd_end <= 1'b0;
      end else if (scl && scl_q && !sda_q && sda) begin // stop: data rises, clock high
         n_stop <= n_stop + 1;
      end else if (scl && !scl_q) begin
         bitc <= bitc + 4'h1;
         if (bitc < 4'h8) sh <= {sh[6:0], sda}; // eight bits, msb first
         if (bitc == 4'h8 && rd && sda) rd_end <= 1'b1;
      end else if (!scl && scl_q) begin
         if (bitc == 4'h8 && !rd) begin // ack slot, direction from address byte
            sda_pull <= !nak_all;
            log_q[n_log] <= sh;
            n_log <= n_log + 1;
            if (first) rd <= sh[0] && !nak_all; // a refusing slave never answers
         end else if (bitc == 4'h9) begin
            bitc <= 4'h0;
            first <= 1'b0;
            sda_pull <= rd && !rd_end && !rd_byte[7];
         end else begin // released in the ack slot of a read
            sda_pull <= rd && bitc < 4'h8 && !rd_byte[3'h7 - bitc[2:0]];
         end
      end
   end
endmodule

// ---- dv/tb_two_wire_master_regs.sv ----
// Purpose: self-checking bench of the two-wire master and its registers
// Assumes: zero-wait AHB-Lite slave, one slave model on the wire
// Notes: short waveform so frames last a few hundred cycles
`include "twm_map.svh"
module tb_two_wire_master_regs;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [7:0] haddr = 8'h00;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] rdat;
   logic nak_all = 1'b0;
   logic scl_o, scl_oe, sda_o, sda_oe, irq, s_pull, scl_w, sda_w;
   twm_pkg::twm_ahb_req_t ahb_req;
   twm_pkg::twm_ahb_rsp_t ahb_rsp;
   int miscompares = 0;
   int tests_run = 0;
   assign ahb_req = '{hsel, {24'h00_0000, haddr}, htrans, hwrite, 3'h2, hwdata, ahb_rsp.hreadyout};
   assign scl_w = !scl_oe;
   assign sda_w = !sda_oe && !s_pull;
   always #2 sys_clk = ~sys_clk;
   twm_regs_top DUT (.sys_clk(sys_clk), .rst(rst), .ahb_req(ahb_req), .ahb_rsp(ahb_rsp), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
   twm_slave_model slave (.sys_clk(sys_clk), .scl(scl_w), .sda(sda_w), .nak_all(nak_all), .rd_byte(8'h6E),
      .sda_pull(s_pull));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic final_report();
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, seen);
         miscompares++;
      end
   endtask
   task automatic expire(input logic hit);
      if (hit) begin
         miscompares++;
         final_report();
      end
   endtask
   task automatic wait_rdy();
      int k;
      for (k = 0; k < 50; k++) begin
         @(posedge sys_clk);
         if (ahb_rsp.hreadyout === 1'b1) break;
      end
      if (k == 50) begin
         miscompares++;
         final_report();
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      rdat = ahb_rsp.hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0000_0000);
   endtask
   task automatic poll(input int b);
      int k;
      for (k = 0; k < 500; k++) begin
         rd(`TWM_OFS_STAT);
         if (rdat[b] === 1'b1) break;
      end
      if (k == 500) begin
         miscompares++;
         final_report();
      end
   endtask
   task automatic phase(input logic lvl, output int c);
      int k;
      for (k = 0; k < 100 && scl_oe !== lvl; k++) begin
         @(posedge sys_clk);
         #1;
      end
      c = 0;
      while (scl_oe === lvl && c < 100) begin
         @(posedge sys_clk);
         #1;
         c++;
      end
      expire(k == 100 || c == 100);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset_values();
      logic [7:0] ofs [9] = '{`TWM_OFS_CTRL, `TWM_OFS_MODE, 8'h08, `TWM_OFS_INNER, `TWM_OFS_CWG,
         `TWM_OFS_STAT, `TWM_OFS_IMSK, `TWM_OFS_RXHOLD, `TWM_OFS_TXHOLD};
      for (int i = 0; i < 9; i++) begin
         rd(ofs[i]);
         chk("reset value", rdat, (ofs[i] == `TWM_OFS_STAT) ? `TWM_SR_RESET : 32'h0000_0000);
      end
      chk("idle outputs", {ahb_rsp.hresp, scl_o, sda_o, scl_oe, sda_oe, irq}, 32'h0000_0000);
      wr(`TWM_OFS_STAT, 32'hFFFF_FFFF);
      wr(8'h08, 32'hFFFF_FFFF);
      rd(`TWM_OFS_STAT);
      chk("status ignores writes", rdat, `TWM_SR_RESET);
   endtask
   task automatic t_write_frames();
      int lo;
      int hi;
      logic [7:0] exp_b [7] = '{8'hB4, 8'hC3, 8'h96, 8'hB4, 8'hC3, 8'h77, 8'h55};
      wr(`TWM_OFS_CWG, 32'h0001_0102);
      wr(`TWM_OFS_MODE, 32'h005A_0100); // write to 5A, one inner byte
      wr(`TWM_OFS_INNER, 32'h0000_00C3);
      wr(`TWM_OFS_CTRL, 32'h0000_0004);
      rd(`TWM_OFS_STAT);
      chk("status enabled", rdat, 32'h0000_000D);
      wr(`TWM_OFS_TXHOLD, 32'h0000_0096); // launches without start
      phase(1'b1, lo);
      phase(1'b0, hi);
      chk("low time", lo, 7);
      chk("high time", hi, 5);
      rd(`TWM_OFS_STAT);
      chk("status in frame", rdat, 32'h0000_0008);
      poll(2);
      wr(`TWM_OFS_CTRL, 32'h0000_0002); // stop before the last acknowledge
      wr(`TWM_OFS_TXHOLD, 32'h0000_0077);
      poll(0);
      chk("stop after current byte", slave.n_log, 3);
      wr(`TWM_OFS_CTRL, 32'h0000_0001);
      poll(2);
      wr(`TWM_OFS_TXHOLD, 32'h0000_0055);
      poll(0);
      for (int i = 0; i < 7; i++) chk("wire byte", slave.log_q[i], exp_b[i]);
      chk("bytes sent", slave.n_log, 7);
      chk("stops seen", slave.n_stop, 2);
   endtask
   task automatic t_nak_irq();
      int k;
      nak_all <= 1'b1;
      wr(`TWM_OFS_IEN, 32'h0000_0100);
      wr(`TWM_OFS_MODE, 32'h005A_1000); // read direction, no inner bytes
      wr(`TWM_OFS_TXHOLD, 32'h0000_00A5); // stored only, no launch when reading
      wr(`TWM_OFS_CTRL, 32'h0000_0001);
      for (k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge sys_clk);
      expire(k == 2000);
      @(negedge sys_clk);
      chk("irq on nak", irq, 1'b1);
      nak_all <= 1'b0;
      rd(`TWM_OFS_STAT);
      chk("status on nak", rdat, 32'h0000_010D);
      rd(`TWM_OFS_STAT);
      chk("nak cleared", rdat, 32'h0000_000D);
      @(negedge sys_clk);
      chk("irq after clear", irq, 1'b0);
      wr(`TWM_OFS_IDIS, 32'h0000_0100);
      wr(`TWM_OFS_IEN, 32'h0000_0007);
      rd(`TWM_OFS_IMSK);
      chk("mask set", rdat, 32'h0000_0007);
      chk("irq from done", irq, 1'b1);
      wr(`TWM_OFS_IDIS, 32'h0000_0007);
      rd(`TWM_OFS_IMSK);
      chk("mask cleared", rdat, 32'h0000_0000);
      chk("irq masked", irq, 1'b0);
   endtask
   task automatic t_read_frame();
      logic [7:0] exp_r [4] = '{8'hB4, 8'hA1, 8'hB2, 8'hB5};
      wr(`TWM_OFS_MODE, 32'h005A_1200); // read, two inner bytes
      wr(`TWM_OFS_INNER, 32'h0000_A1B2);
      wr(`TWM_OFS_CTRL, 32'h0000_0003); // one byte: start and stop together
      poll(0);
      chk("status after read", rdat, 32'h0000_000F);
      for (int i = 0; i < 4; i++) chk("read frame byte", slave.log_q[i + 8], exp_r[i]);
      rd(`TWM_OFS_RXHOLD);
      chk("received byte", rdat, 32'h0000_006E);
      rd(`TWM_OFS_STAT);
      chk("receive flag cleared", rdat, 32'h0000_000D);
      chk("stops seen", slave.n_stop, 4);
   endtask
   task automatic t_disable();
      wr(`TWM_OFS_CTRL, 32'h0000_0008);
      wr(`TWM_OFS_CTRL, 32'h0000_000C);
      wr(`TWM_OFS_MODE, 32'h005A_0000);
      wr(`TWM_OFS_TXHOLD, 32'h0000_003C);
      @(posedge sys_clk);
      @(negedge sys_clk);
      chk("no launch when disabled", sda_oe, 1'b0);
      rd(`TWM_OFS_STAT);
      chk("status disabled", rdat, 32'h0000_0009);
      wr(`TWM_OFS_CTRL, 32'h0000_0004);
      rd(`TWM_OFS_STAT);
      chk("status re-enabled", rdat, 32'h0000_000D);
   endtask
   task automatic t_soft_reset();
      wr(`TWM_OFS_IEN, 32'h0000_0107);
      wr(`TWM_OFS_CTRL, 32'h0000_0080);
      t_reset_values();
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      t_reset_values();
      t_write_frames();
      t_nak_irq();
      t_read_frame();
      t_disable();
      t_soft_reset();
      final_report();
   end
endmodule
